// File: rtl/pswmc_defines.vh
`ifndef PSWMC_DEFINES_VH
`define PSWMC_DEFINES_VH

// mode encodings
`define PSWMC_MODE_W 2
`define PSWMC_MODE_LOCKOUT 2'h0
`define PSWMC_MODE_NORMAL 2'h1
`define PSWMC_MODE_STANDBY 2'h2
`define PSWMC_MODE_SLEEP 2'h3

// timing counts in 40 ns clocks at 25 MHz
`define PSWMC_TIMER_W 20
// 75 us standby timeout
`define PSWMC_STANDBY_CYCLES 20'h0_0753
// 10 ms sleep timeout, counted on from standby entry
`define PSWMC_SLEEP_CYCLES 20'h3_d090

// reset value of every single-bit output flop
`define PSWMC_OUT_RESET 1'b0

`endif

// File: rtl/pswmc_mode_controller.v
`include "pswmc_defines.vh"
`default_nettype none

// Behaviour
// R1: hold everything disabled while supply below rising lockout threshold.
// R2: in lockout, gate driver off and transistor off regardless of pulse input.
// R3: after supply good, enter normal mode only when pulse input goes high.
// R4: supply below falling threshold returns to lockout from any mode.
// R5: normal mode keeps all blocks active with gate driver enabled.
// R6: in normal mode transistor follows pulse input level.
// R7: current-sense output enabled during each on-time in normal mode.
// R8: pulse low for standby timeout in normal mode enters standby.
// R9: standby disables gate driver and current-sense circuitry.
// R10: pulse low further for sleep timeout moves standby into sleep.
// R11: sleep disables gate driver and remaining internal circuitry.
// R12: first rising pulse edge in standby or sleep wakes to normal, within bounds.
// R13: any high pulse level restarts the inactivity timer.
// R14: external controller allows for wake latency; first pulse may be shortened.
// R15: sleep entry typically 11 ms from pulse low (here 75 us + 10 ms = 10.075 ms); wake from sleep at most 1.1 us.
module pswmc_mode_controller #(
  parameter [`PSWMC_TIMER_W-1:0] STANDBY_CYCLES = `PSWMC_STANDBY_CYCLES,
  parameter [`PSWMC_TIMER_W-1:0] SLEEP_CYCLES = `PSWMC_SLEEP_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire supply_above_rising,
  input wire supply_below_falling,
  input wire pulse_in,
  output reg gate_drive_enable,
  output reg transistor_on,
  output reg current_sense_enable,
  output reg internal_active,
  output reg [`PSWMC_MODE_W-1:0] mode
);

  // internal reset, released two clocks after rstn
  reg rst_sync1;
  reg rst_sync2;
  wire rst_int_n;
  reg pulse_prev;
  reg [`PSWMC_TIMER_W-1:0] idle_timer;
  reg [`PSWMC_TIMER_W-1:0] next_idle_timer;
  reg [`PSWMC_MODE_W-1:0] next_mode;
  reg next_gate_drive_enable;
  reg next_transistor_on;
  reg next_current_sense_enable;
  reg next_internal_active;
  wire pulse_rise;
  wire wake_req;
  wire supply_good;
  wire standby_due;
  wire sleep_due;

  localparam [`PSWMC_TIMER_W-1:0] TIMER_ZERO = {`PSWMC_TIMER_W{1'b0}};
  localparam [`PSWMC_TIMER_W-1:0] TIMER_ONE = {{(`PSWMC_TIMER_W-1){1'b0}}, 1'b1};
  localparam [`PSWMC_TIMER_W-1:0] TIMER_MAX = {`PSWMC_TIMER_W{1'b1}};
  localparam [`PSWMC_TIMER_W-1:0] STBY_LIMIT = STANDBY_CYCLES;
  localparam [`PSWMC_TIMER_W-1:0] SLEEP_LIMIT = SLEEP_CYCLES;
  // last timer values before each timeout fires; sleep counts on from standby entry
  // limitation: the sum must stay below the saturation value of the timer
  localparam [`PSWMC_TIMER_W-1:0] STBY_LAST = STBY_LIMIT - TIMER_ONE;
  localparam [`PSWMC_TIMER_W-1:0] SLEEP_LAST = STBY_LIMIT + SLEEP_LIMIT - TIMER_ONE;

  // mode decodes shared by the transition logic and the output flops
  function is_normal;
    input [`PSWMC_MODE_W-1:0] m;
    begin
      is_normal = (m == `PSWMC_MODE_NORMAL);
    end
  endfunction

  function is_powered;
    input [`PSWMC_MODE_W-1:0] m;
    begin
      is_powered = (m == `PSWMC_MODE_NORMAL) || (m == `PSWMC_MODE_STANDBY);
    end
  endfunction

  function is_low_power;
    input [`PSWMC_MODE_W-1:0] m;
    begin
      is_low_power = (m == `PSWMC_MODE_STANDBY) || (m == `PSWMC_MODE_SLEEP);
    end
  endfunction

  // reset enters at once but leaves on a clock edge, avoiding recovery hazards
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  assign rst_int_n = rst_sync2;

  // reset low to match the idle pulse level, so reset makes no false edge
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pulse_prev <= 1'b0;
    end else begin
      pulse_prev <= pulse_in;
    end
  end

  assign pulse_rise = pulse_in & ~pulse_prev;
  assign wake_req = pulse_rise & is_low_power(mode);
  assign supply_good = supply_above_rising & ~supply_below_falling;
  assign standby_due = ~pulse_in & (idle_timer >= STBY_LAST);
  assign sleep_due = ~pulse_in & (idle_timer >= SLEEP_LAST);

  // saturating so a long idle never wraps back into a false timeout
  always @* begin
    next_idle_timer = idle_timer;
    if (pulse_in || (mode == `PSWMC_MODE_LOCKOUT)) begin
      next_idle_timer = TIMER_ZERO; // [R13]
    end else if (idle_timer != TIMER_MAX) begin
      next_idle_timer = idle_timer + TIMER_ONE;
    end
  end

  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      idle_timer <= TIMER_ZERO;
    end else begin
      idle_timer <= next_idle_timer;
    end
  end

  always @* begin
    next_mode = mode;
    case (mode)
      `PSWMC_MODE_LOCKOUT: begin
        if (supply_good && pulse_in) begin
          next_mode = `PSWMC_MODE_NORMAL; // [R3]
        end
      end
      `PSWMC_MODE_NORMAL: begin
        if (standby_due) begin
          next_mode = `PSWMC_MODE_STANDBY; // [R8]
        end
      end
      `PSWMC_MODE_STANDBY: begin
        if (wake_req) begin
          next_mode = `PSWMC_MODE_NORMAL; // [R12]
        end else if (sleep_due) begin
          next_mode = `PSWMC_MODE_SLEEP; // [R10] [R15]
        end
      end
      `PSWMC_MODE_SLEEP: begin
        if (wake_req) begin
          next_mode = `PSWMC_MODE_NORMAL; // [R12] [R15]
        end
      end
      default: begin
        next_mode = `PSWMC_MODE_LOCKOUT;
      end
    endcase
    // falling supply overrides every other transition
    if (supply_below_falling) begin
      next_mode = `PSWMC_MODE_LOCKOUT; // [R4]
    end
  end

  // lockout is the reset state, so nothing switches until supply and pulse agree
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mode <= `PSWMC_MODE_LOCKOUT;
    end else begin
      mode <= next_mode;
    end
  end

  // outputs follow the next mode, so wake costs one clock (40 ns), inside both bounds
  always @* begin
    next_gate_drive_enable = is_normal(next_mode); // [R2] [R5] [R9] [R11]
    next_transistor_on = is_normal(next_mode) && pulse_in; // [R2] [R6]
    next_current_sense_enable = is_normal(next_mode) && pulse_in; // [R7] [R9]
    next_internal_active = is_powered(next_mode); // [R1] [R5] [R11]
  end

  // gate driver enable
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      gate_drive_enable <= `PSWMC_OUT_RESET;
    end else begin
      gate_drive_enable <= next_gate_drive_enable;
    end
  end

  // transistor command; the first clock of a wake pulse is kept
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      transistor_on <= `PSWMC_OUT_RESET;
    end else begin
      transistor_on <= next_transistor_on;
    end
  end

  // current-sense output enable, only during on-time
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      current_sense_enable <= `PSWMC_OUT_RESET;
    end else begin
      current_sense_enable <= next_current_sense_enable;
    end
  end

  // internal circuitry kept powered in normal and standby only
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      internal_active <= `PSWMC_OUT_RESET;
    end else begin
      internal_active <= next_internal_active;
    end
  end

endmodule // pswmc_mode_controller

`default_nettype wire

// File: bench/pswmc_monitor.sv
`default_nettype none
module pswmc_monitor(
input wire logic clk,
input wire logic rstn,
input wire logic supply_below_falling,
input wire logic pulse_in,
input wire logic gate_drive_enable,
input wire logic transistor_on,
input wire logic current_sense_enable,
input wire logic internal_active,
input wire logic [1:0] mode);
timeunit 1ns;timeprecision 1ns;
default clocking @(posedge clk);endclocking
default disable iff(!rstn);
property p_lk;mode==0|->!gate_drive_enable&&!transistor_on&&!internal_active&&!current_sense_enable;endproperty
a_lk:assert property(p_lk)else $error("lk");
property p_fl;supply_below_falling|=>mode==0;endproperty
a_fl:assert property(p_fl)else $error("fl");
property p_gd;gate_drive_enable==(mode==1);endproperty
a_gd:assert property(p_gd)else $error("gd");
property p_tr;mode==1|->transistor_on==$past(pulse_in);endproperty
a_tr:assert property(p_tr)else $error("tr");
property p_cs;current_sense_enable==transistor_on;endproperty
a_cs:assert property(p_cs)else $error("cs");
property p_sb;mode==2|->!current_sense_enable&&internal_active;endproperty
a_sb:assert property(p_sb)else $error("sb");
property p_en;$changed(mode)&&mode==2|->$past(mode)==1&&!$past(pulse_in);endproperty
a_en:assert property(p_en)else $error("en");
property p_wk;mode[1]&&pulse_in&&!$past(pulse_in)&&!supply_below_falling|=>mode==1;endproperty
a_wk:assert property(p_wk)else $error("wk");
property p_sl;mode==3|->!gate_drive_enable&&!internal_active&&!current_sense_enable;endproperty
a_sl:assert property(p_sl)else $error("sl");
property p_sp;$changed(mode)&&mode==3|->$past(mode)==2;endproperty
a_sp:assert property(p_sp)else $error("sp");
cover property(mode==2);
cover property(mode==3);
cover property(mode==3 ##1 mode==1);
endmodule // pswmc_monitor
`default_nettype wire
bind pswmc_mode_controller pswmc_monitor i_mon(.*);

// File: bench/pswmc_pwm_src.sv
`default_nettype none
module pswmc_pwm_src(
input wire logic clk,
input wire logic en,
output logic pulse_in=0);
timeunit 1ns;timeprecision 1ns;
logic [2:0] c=0;
always @(posedge clk) begin // five-cycle pulses, repeating every eight clocks
c<=en?c+3'h1:3'h0;
pulse_in<=en&&c<3'h5;
end
endmodule // pswmc_pwm_src
`default_nettype wire

// File: bench/pswmc_tb_top.sv
`default_nettype none
module pswmc_tb_top;
timeunit 1ns;timeprecision 1ns;
logic clk=0,rstn=0,supply_above_rising=0,supply_below_falling=0,en=0,pulse_in;
wire gate_drive_enable,transistor_on,current_sense_enable,internal_active;
wire [1:0] mode;
int n_errors=0,cmp_count=0;
initial forever #20 clk=~clk;
pswmc_pwm_src i_pswmc_pwm_src(.*);
pswmc_mode_controller #(.STANDBY_CYCLES(20'h0_0008),.SLEEP_CYCLES(20'h0_0014)) i_pswmc_mode_controller(.*);
task results;if(n_errors==0&&cmp_count>0)$display("TB: PASS");else $display("TB: FAIL");$finish;endtask
task st(int n);repeat(n)@(posedge clk);endtask
task ck(logic [1:0] e);
cmp_count++;if(mode!==e)begin n_errors++;$display("wrong value mode %h %h",e,mode);end
cmp_count++;if(gate_drive_enable!==(e==2'h1))begin n_errors++;$display("wrong value gate_drive_enable %b %b",e==2'h1,gate_drive_enable);end
cmp_count++;if(internal_active!==(e==2'h1||e==2'h2))begin n_errors++;$display("wrong value internal_active %b %b",e==2'h1||e==2'h2,internal_active);end
cmp_count++;if(e!=2'h1&&(transistor_on!==1'b0||current_sense_enable!==1'b0))begin n_errors++;$display("wrong value transistor_on %b %b",1'b0,transistor_on);end
endtask
task t_run;en<=1;st(20);ck(2'h0);
supply_above_rising<=1;st(30);ck(2'h1);
endtask
task t_idle;@(posedge clk iff pulse_in);en<=0;st(8);ck(2'h1);
st(4);ck(2'h2);
st(22);ck(2'h3);
en<=1;st(4);ck(2'h1);
endtask
task t_fall;supply_below_falling<=1;st(3);ck(2'h0);
endtask
initial begin st(12);rstn<=1;t_run;t_idle;t_fall;results;end
initial begin st(2000);n_errors++;results;end
endmodule // pswmc_tb_top
`default_nettype wire
